// File: inc/ocp_pkg.sv
/*
 * Constants, register indices, field positions and codes for one output
 * channel phase configuration slice.
 * Assumes an AXI4-Lite master with 32-bit data; each register is one word
 * at byte address four times its index.
 */
package ocp_pkg;

  // ------------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------------
  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 32;
  localparam int          IDX_LSB      = 2;
  localparam int          IDX_W        = 9;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ------------------------------------------------------------------
  // Register indices
  // ------------------------------------------------------------------
  localparam logic [8:0]  IDX_CTRL      = 9'h0C8;
  localparam logic [8:0]  IDX_DIV_LOW   = 9'h0C9;
  localparam logic [8:0]  IDX_DIV_HIGH  = 9'h0CA;
  localparam logic [8:0]  IDX_FINE      = 9'h0CB;
  localparam logic [8:0]  IDX_COARSE    = 9'h0CC;
  localparam logic [8:0]  IDX_SLIP_LOW  = 9'h0CD;
  localparam logic [8:0]  IDX_SLIP_HIGH = 9'h0CE;
  localparam logic [8:0]  IDX_SRC       = 9'h0CF;
  localparam logic [8:0]  IDX_IDLE      = 9'h0D0;
  localparam logic [8:0]  IDX_SLIP_CMD  = 9'h0D1;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CTRL_CHAN_EN  = 0;
  localparam int CTRL_MULTI_EN = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_SLIP_EN  = 5;
  localparam int CTRL_SYNC_EN  = 6;
  localparam int IDLE_DYN_DRV  = 5;
  localparam int IDLE_LVL_LSB  = 6;
  localparam int STAT_CNT_LSB  = 4;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_RST_DEVICE_CLOCK_OUTPUT = 8'h02;
  localparam logic [7:0] CTRL_RST_SREF = 8'h00;
  localparam logic [7:0] DIV_LOW_RST   = 8'h02;
  localparam logic [7:0] REG_RST       = 8'h00;

  // ------------------------------------------------------------------
  // Delay limits
  // ------------------------------------------------------------------
  localparam int          FINE_STEP_PS = 25;
  localparam logic [4:0]  FINE_MAX     = 5'h17;
  localparam logic [4:0]  COARSE_MAX   = 5'h11;
  localparam int          COARSE_TAPS  = 17;

  // ------------------------------------------------------------------
  // Codes
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_ASYNC   = 2'h0,
    MODE_DYNAMIC = 2'h3
  } ocp_mode_t;

  typedef enum logic [1:0] {
    SRC_DIVIDER = 2'h0,
    SRC_ANALOG  = 2'h1,
    SRC_PARTNER = 2'h2,
    SRC_VCO     = 2'h3
  } ocp_src_t;

  localparam logic [1:0] IDLE_NORMAL = 2'h0;
  localparam logic [1:0] IDLE_LOW    = 2'h2;

endpackage : ocp_pkg

// File: core/ocp_slip_repeat.sv
/*
 * Slip sequencer: turns slip requests into a run of one-cycle stalls of
 * the channel divider, one stall per VCO cycle of phase shift.
 * Assumes request inputs are single-cycle pulses on clock.
 */
`timescale 1ns/100ps
module ocp_slip_repeat
  import ocp_pkg::*;
#(
  parameter int CNT_W = 12
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  // Requests
  input  wire logic             manualReq,
  input  wire logic             autoReq,
  // Settings
  input  wire logic             slipEnable,
  input  wire logic             multiEnable,
  input  wire logic [CNT_W-1:0] slipCount,
  // Results
  output logic                  stall,
  output logic                  busy,
  output logic [CNT_W-1:0]      remaining
);

  typedef enum logic [0:0] {
    SR_IDLE = 1'h0,
    SR_SLIP = 1'h1
  } ocp_slip_t;

  ocp_slip_t        state_r, state_nxt;
  logic [CNT_W-1:0] remain_r, remain_nxt;
  logic [CNT_W-1:0] load;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    load       = '0;
    state_nxt  = state_r;
    remain_nxt = remain_r;
    if (slipEnable && manualReq) begin                              // [R12]
      load = multiEnable ? slipCount : CNT_W'(1);              // [R05] [R12]
    end else if (slipEnable && multiEnable && autoReq) begin        // [R10]
      load = slipCount;                                             // [R05]
    end
    unique case (state_r)
      SR_IDLE: begin
        if (load != '0) begin
          state_nxt  = SR_SLIP;
          remain_nxt = load;
        end
      end
      SR_SLIP: begin
        remain_nxt = remain_r - CNT_W'(1);
        if (remain_r == CNT_W'(1)) begin
          state_nxt = SR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_r  <= SR_IDLE;
      remain_r <= '0;
    end else begin
      state_r  <= state_nxt;
      remain_r <= remain_nxt;
    end
  end

  assign stall     = (state_r == SR_SLIP);
  assign busy      = stall;
  assign remaining = remain_r;

endmodule : ocp_slip_repeat

// File: core/ocp_out_path.sv
/*
 * Output path: coarse flip-flop delay line, source multiplexer, idle
 * forcing and driver enable for one channel.
 * Assumes all clock-like inputs are levels sampled on clock.
 */
`timescale 1ns/100ps
module ocp_out_path
  import ocp_pkg::*;
#(
  parameter int TAPS = COARSE_TAPS
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Sources
  input  wire logic       divClock,
  input  wire logic       partnerClock,
  input  wire logic       vcoClock,
  // Settings
  input  wire logic [4:0] coarseCode,
  input  wire logic [1:0] sourceSel,
  input  wire logic       pulseMode,
  input  wire logic [1:0] idleLevel,
  input  wire logic       dynDriver,
  input  wire logic       chanEnable,
  input  wire logic       pulseGenActive,
  // Outputs
  output logic            channelOut,
  output logic            driverEnable
);

  logic [TAPS-1:0] tap_r, tap_nxt;
  logic [4:0]      coarseEff;
  logic            delayed;
  logic            muxOut;
  logic            out_r, out_nxt;
  logic            drv_r, drv_nxt;

  // ------------------------------------------------------------------
  // Coarse delay line
  // ------------------------------------------------------------------
  assign tap_nxt[0] = divClock;
  for (genvar i = 1; i < TAPS; i++) begin : g_tap
    assign tap_nxt[i] = tap_r[i-1];
  end

  always_comb begin
    coarseEff = (coarseCode > COARSE_MAX) ? COARSE_MAX : coarseCode; // [R03]
    delayed   = (coarseEff == '0) ? divClock : tap_r[coarseEff - 5'h01];
  end

  // ------------------------------------------------------------------
  // Source select, idle level and driver
  // ------------------------------------------------------------------
  always_comb begin
    unique case (ocp_src_t'(sourceSel))                             // [R06]
      SRC_DIVIDER: muxOut = delayed;
      SRC_ANALOG:  muxOut = delayed;
      SRC_PARTNER: muxOut = partnerClock;
      SRC_VCO:     muxOut = vcoClock;
    endcase
    out_nxt = chanEnable & muxOut;
    if (pulseMode && idleLevel == IDLE_LOW && !pulseGenActive) begin
      out_nxt = 1'b0;                                               // [R08]
    end
    if (pulseMode && dynDriver) begin
      drv_nxt = chanEnable & pulseGenActive;                        // [R09]
    end else begin
      drv_nxt = chanEnable;                                         // [R09]
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      tap_r <= '0;
      out_r <= 1'b0;
      drv_r <= 1'b0;
    end else begin
      tap_r <= tap_nxt;
      out_r <= out_nxt;
      drv_r <= drv_nxt;
    end
  end

  assign channelOut   = out_r;
  assign driverEnable = drv_r;

endmodule : ocp_out_path

// File: core/ocp_channel.sv
/*
 * One output channel: AXI4-Lite register file, 12-bit divider with slip
 * and sync handling, fine delay code and the output path.
 * Assumes clock stands for the VCO clock; event inputs are one-cycle
 * pulses synchronous to clock.
 */
//
// Contract
// [R01] Divide ratio joins upper nibble and low byte
// [R02] Fine delay codes above 23 clamp
// [R03] Coarse delay codes above 17 clamp
// [R04] Slip count split low byte, high nibble
// [R05] Multislip repeats each slip count times
// [R06] Source select: divider, analog, partner, VCO
// [R07] Ratio one passes VCO clock through
// [R08] Idle code 10 forces low, pulse mode
// [R09] Dynamic driver follows pulse generator events
// [R10] Multislip default by channel type; auto slips
// [R11] Start-up mode 00 async, 11 dynamic
// [R12] Slips need slip enable; single cycle
// [R13] Software avoids reserved bits and codes
`timescale 1ns/100ps
module ocp_channel
  import ocp_pkg::*;
#(
  parameter bit SYNC_REF = 1'b0,
  parameter int DIV_W    = 12
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rstn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  // AXI4-Lite write data
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Channel events
  input  wire logic              generalInputPinSlip,
  input  wire logic              syncEvent,
  input  wire logic              pulseGenEvent,
  input  wire logic              pulseGenActive,
  input  wire logic              partnerClock,
  // Channel outputs
  output logic                   deviceClockOutput,
  output logic                   driverEnable,
  output logic [4:0]             fineDelayCode,
  output logic [DIV_W-1:0]       divideRatio,
  output logic                   slipBusy
);

  localparam logic [7:0] CTRL_RST = SYNC_REF ? CTRL_RST_SREF : CTRL_RST_DEVICE_CLOCK_OUTPUT;

  // ------------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------------
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] divLow_r, divLow_nxt;
  logic [7:0] divHigh_r, divHigh_nxt;
  logic [7:0] fine_r, fine_nxt;
  logic [7:0] coarse_r, coarse_nxt;
  logic [7:0] slipLow_r, slipLow_nxt;
  logic [7:0] slipHigh_r, slipHigh_nxt;
  logic [7:0] src_r, src_nxt;
  logic [7:0] idle_r, idle_nxt;
  logic       swSlip_r, swSlip_nxt;

  // Bus state
  logic              awHeld_r, awHeld_nxt;
  logic              wHeld_r, wHeld_nxt;
  logic [IDX_W-1:0]  wIdx_r, wIdx_nxt;
  logic [7:0]        wByte_r, wByte_nxt;
  logic              wLane_r, wLane_nxt;
  logic              bvalid_r, bvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic [1:0]        rresp_r, rresp_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic              doWrite;
  logic              wHit;
  logic [IDX_W-1:0]  rIdx;
  logic              rHit;
  logic [DATA_W-1:0] rWord;

  // Channel state
  logic [DIV_W-1:0]  divCnt_r, divCnt_nxt;
  logic              vco_r, vco_nxt;
  logic              divClock;
  logic [DIV_W-1:0]  ratio;
  logic [11:0]       slipCount;
  logic              slipStall;
  logic [11:0]       slipRemain;
  logic              pulseMode;
  logic              syncTake;
  logic              chanEn;

  // ------------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------------
  always_comb begin
    ratio     = {divHigh_r[3:0], divLow_r};                         // [R01]
    slipCount = {slipHigh_r[3:0], slipLow_r};                       // [R04]
    chanEn    = ctrl_r[CTRL_CHAN_EN];
    // Reserved start-up codes behave as asynchronous
    pulseMode = (ctrl_r[CTRL_MODE_LSB +: 2] == MODE_DYNAMIC);       // [R11]
    syncTake  = syncEvent & ctrl_r[CTRL_SYNC_EN];
    fineDelayCode = (fine_r[4:0] > FINE_MAX) ? FINE_MAX : fine_r[4:0]; // [R02]
  end

  // ------------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------------
  assign awready = !awHeld_r && !bvalid_r;
  assign wready  = !wHeld_r && !bvalid_r;
  assign doWrite = awHeld_r && wHeld_r;

  always_comb begin
    awHeld_nxt = awHeld_r;
    wHeld_nxt  = wHeld_r;
    wIdx_nxt   = wIdx_r;
    wByte_nxt  = wByte_r;
    wLane_nxt  = wLane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    if (awvalid && awready) begin
      awHeld_nxt = 1'b1;
      wIdx_nxt   = awaddr[IDX_LSB +: IDX_W];
    end
    if (wvalid && wready) begin
      wHeld_nxt = 1'b1;
      wByte_nxt = wdata[7:0];
      wLane_nxt = wstrb[0];
    end
    if (doWrite) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = wHit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_comb begin
    wHit = (wIdx_r >= IDX_CTRL) && (wIdx_r <= IDX_SLIP_CMD);
    ctrl_nxt     = ctrl_r;
    divLow_nxt   = divLow_r;
    divHigh_nxt  = divHigh_r;
    fine_nxt     = fine_r;
    coarse_nxt   = coarse_r;
    slipLow_nxt  = slipLow_r;
    slipHigh_nxt = slipHigh_r;
    src_nxt      = src_r;
    idle_nxt     = idle_r;
    swSlip_nxt   = 1'b0;
    if (doWrite && wLane_r) begin
      unique case (wIdx_r)
        IDX_CTRL:      ctrl_nxt     = wByte_r;
        IDX_DIV_LOW:   divLow_nxt   = wByte_r;
        IDX_DIV_HIGH:  divHigh_nxt  = wByte_r;
        IDX_FINE:      fine_nxt     = wByte_r;
        IDX_COARSE:    coarse_nxt   = wByte_r;
        IDX_SLIP_LOW:  slipLow_nxt  = wByte_r;                     // [R04]
        IDX_SLIP_HIGH: slipHigh_nxt = wByte_r;                     // [R04]
        IDX_SRC:       src_nxt      = wByte_r;
        IDX_IDLE:      idle_nxt     = wByte_r;
        IDX_SLIP_CMD:  swSlip_nxt   = wByte_r[0];
        default:       swSlip_nxt   = 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------------
  assign arready = !rvalid_r;

  always_comb begin
    rIdx  = araddr[IDX_LSB +: IDX_W];
    rHit  = 1'b1;
    rWord = '0;
    unique case (rIdx)
      IDX_CTRL:      rWord[7:0] = ctrl_r;
      IDX_DIV_LOW:   rWord[7:0] = divLow_r;
      IDX_DIV_HIGH:  rWord[7:0] = divHigh_r;
      IDX_FINE:      rWord[7:0] = fine_r;
      IDX_COARSE:    rWord[7:0] = coarse_r;
      IDX_SLIP_LOW:  rWord[7:0] = slipLow_r;
      IDX_SLIP_HIGH: rWord[7:0] = slipHigh_r;
      IDX_SRC:       rWord[7:0] = src_r;
      IDX_IDLE:      rWord[7:0] = idle_r;
      IDX_SLIP_CMD: begin
        rWord[0]                    = slipStall;
        rWord[STAT_CNT_LSB +: 12]   = slipRemain;
      end
      default:       rHit = 1'b0;
    endcase
    rvalid_nxt = rvalid_r;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = rHit ? RESP_OKAY : RESP_SLVERR;
      rdata_nxt  = rWord;
    end else if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Divider with slip and sync
  // ------------------------------------------------------------------
  always_comb begin
    vco_nxt    = ~vco_r;
    divCnt_nxt = divCnt_r;
    if (!chanEn || syncTake) begin
      divCnt_nxt = '0;
    end else if (!slipStall) begin                            // [R05] [R12]
      divCnt_nxt = (divCnt_r + DIV_W'(1) >= ratio) ? '0
                                                   : divCnt_r + DIV_W'(1);
    end
    if (ratio <= DIV_W'(1)) begin
      divClock = vco_r;                                             // [R07]
    end else begin
      divClock = (divCnt_r < (ratio >> 1));                         // [R01]
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_r     <= CTRL_RST;                                       // [R10]
      divLow_r   <= DIV_LOW_RST;
      divHigh_r  <= REG_RST;
      fine_r     <= REG_RST;
      coarse_r   <= REG_RST;
      slipLow_r  <= REG_RST;
      slipHigh_r <= REG_RST;
      src_r      <= REG_RST;
      idle_r     <= REG_RST;
      swSlip_r   <= 1'b0;
      awHeld_r   <= 1'b0;
      wHeld_r    <= 1'b0;
      wIdx_r     <= '0;
      wByte_r    <= '0;
      wLane_r    <= 1'b0;
      bvalid_r   <= 1'b0;
      bresp_r    <= RESP_OKAY;
      rvalid_r   <= 1'b0;
      rresp_r    <= RESP_OKAY;
      rdata_r    <= '0;
      divCnt_r   <= '0;
      vco_r      <= 1'b0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      divLow_r   <= divLow_nxt;
      divHigh_r  <= divHigh_nxt;
      fine_r     <= fine_nxt;
      coarse_r   <= coarse_nxt;
      slipLow_r  <= slipLow_nxt;
      slipHigh_r <= slipHigh_nxt;
      src_r      <= src_nxt;
      idle_r     <= idle_nxt;
      swSlip_r   <= swSlip_nxt;
      awHeld_r   <= awHeld_nxt;
      wHeld_r    <= wHeld_nxt;
      wIdx_r     <= wIdx_nxt;
      wByte_r    <= wByte_nxt;
      wLane_r    <= wLane_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      rvalid_r   <= rvalid_nxt;
      rresp_r    <= rresp_nxt;
      rdata_r    <= rdata_nxt;
      divCnt_r   <= divCnt_nxt;
      vco_r      <= vco_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Slip sequencer and output path
  // ------------------------------------------------------------------
  ocp_slip_repeat #(
    .CNT_W       (12)
  ) u_slip (
    .clock       (clock),
    .rstn        (rstn),
    .manualReq   (swSlip_r | generalInputPinSlip),                 // [R12]
    .autoReq     (syncTake | pulseGenEvent),                       // [R10]
    .slipEnable  (ctrl_r[CTRL_SLIP_EN]),
    .multiEnable (ctrl_r[CTRL_MULTI_EN]),
    .slipCount   (slipCount),
    .stall       (slipStall),
    .busy        (slipBusy),
    .remaining   (slipRemain)
  );

  ocp_out_path #(
    .TAPS           (COARSE_TAPS)
  ) u_out (
    .clock          (clock),
    .rstn           (rstn),
    .divClock       (divClock),
    .partnerClock   (partnerClock),
    .vcoClock       (vco_r),
    .coarseCode     (coarse_r[4:0]),
    .sourceSel      (src_r[1:0]),
    .pulseMode      (pulseMode),
    .idleLevel      (idle_r[IDLE_LVL_LSB +: 2]),
    .dynDriver      (idle_r[IDLE_DYN_DRV]),
    .chanEnable     (chanEn),
    .pulseGenActive (pulseGenActive),
    .channelOut     (deviceClockOutput),
    .driverEnable   (driverEnable)
  );

  assign bvalid      = bvalid_r;
  assign bresp       = bresp_r;
  assign rvalid      = rvalid_r;
  assign rresp       = rresp_r;
  assign rdata       = rdata_r;
  assign divideRatio = ratio;

endmodule : ocp_channel

// File: bench/ocp_channel_monitor.sv
/*
 * Port checker for ocp_channel: bus answers, fine clamp, divide ratio.
 * Assumes it is bound to ocp_channel and sees only its ports.
 */
`timescale 1ns/100ps
module ocp_channel_monitor
  import ocp_pkg::*;
#(
  parameter int DIV_W = 12
) (
  // Clock, reset and bus
  input wire logic              clock,
  input wire logic              rstn,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              rvalid,
  input wire logic              rready,
  // Channel
  input wire logic [4:0]        fineDelayCode,
  input wire logic [DIV_W-1:0]  divideRatio,
  input wire logic              slipBusy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
  property p_b_late;
    awvalid && awready && wvalid && wready |-> ##2 bvalid;
  endproperty
  a_b_late: assert property (p_b_late) else $error("bvalid late");
  property p_r_late;
    arvalid && arready |=> rvalid;
  endproperty
  a_r_late: assert property (p_r_late) else $error("rvalid late");
  property p_w_refuse;
    bvalid |-> !awready && !wready;
  endproperty
  a_w_refuse: assert property (p_w_refuse) else $error("write taken");
  property p_ar_refuse;
    rvalid |-> !arready;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken");
  property p_fine;
    fineDelayCode <= FINE_MAX;
  endproperty
  a_fine: assert property (p_fine) else $error("fine code high");
  property p_ratio;
    $changed(divideRatio) |-> $rose(bvalid);
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio moved");

  c_slverr: cover property (bvalid && bresp == RESP_SLVERR);
  c_slip: cover property (slipBusy);
  c_read: cover property (rvalid && rready);
endmodule : ocp_channel_monitor

bind ocp_channel ocp_channel_monitor #(.DIV_W(DIV_W)) u_mon (
  .clock, .rstn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
  .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .fineDelayCode,
  .divideRatio, .slipBusy
);

// File: bench/testbench.sv
/*
 * Self-checking bench for ocp_channel: register rows, slips, output.
 * Assumes the design package and the bound port checker.
 */
`timescale 1ns/100ps
module testbench
  import ocp_pkg::*;
;
  typedef struct {bit w; logic [8:0] ix; logic [7:0] d, e;} ocp_row_t;
  typedef struct {logic [7:0] c; logic [11:0] n; int w, e;} ocp_slip_t;
  logic              clock = 1'h0;
  logic              rstn = 1'h0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic              awvalid = 0, wvalid = 0, bready = 0;
  logic              arvalid = 0, rready = 0;
  logic              pinSlip = 0, syncEv = 0, pgEvent = 0;
  logic              pgActive = 0, partnerClk = 0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              devOut, drvEn, slipBusy;
  logic [1:0]        bresp, rresp, rs;
  logic [4:0]        fineCode;
  logic [11:0]       ratio;
  logic [7:0]        rd;
  int                error_cnt = 0, n_checks = 0, busyCnt;
  ocp_row_t rows [9] = '{
    '{0, IDX_CTRL, 8'h00, CTRL_RST_DEVICE_CLOCK_OUTPUT}, '{0, IDX_DIV_LOW, 8'h00, DIV_LOW_RST},
    '{0, IDX_FINE, 8'h00, REG_RST}, '{0, IDX_IDLE, 8'h00, REG_RST},
    '{1, IDX_DIV_HIGH, 8'h0A, 8'h0A}, '{1, IDX_DIV_LOW, 8'h34, 8'h34},
    '{1, IDX_FINE, 8'h1F, 8'h1F}, '{1, IDX_COARSE, 8'h15, 8'h15},
    '{1, IDX_SLIP_HIGH, 8'h0C, 8'h0C}};
  ocp_slip_t slips [7] = '{
    '{8'h23, 12'h005, 0, 5}, '{8'h21, 12'h005, 0, 1},
    '{8'h03, 12'h005, 0, 0}, '{8'h23, 12'h103, 1, 259},
    '{8'h63, 12'h002, 2, 2}, '{8'h21, 12'h005, 1, 0},
    '{8'h23, 12'h005, 3, 5}};

  ocp_channel DUT (
    .clock, .rstn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
    .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .generalInputPinSlip(pinSlip), .syncEvent(syncEv),
    .pulseGenEvent(pgEvent), .pulseGenActive(pgActive),
    .partnerClock(partnerClk), .deviceClockOutput(devOut),
    .driverEnable(drvEn), .fineDelayCode(fineCode), .divideRatio(ratio),
    .slipBusy
  );

  // ------
  // Tasks
  // ------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %0h seen %0h", nm, e, s);
    end
  endtask : chk

  task automatic axw(logic [8:0] ix, logic [7:0] d, output logic [1:0] r);
    @(posedge clock);
    awaddr <= {1'h0, ix, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask : axw

  task automatic axr(logic [8:0] ix, output logic [7:0] d,
                     output logic [1:0] r);
    @(posedge clock);
    araddr <= {1'h0, ix, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'h0;
  endtask : axr

  task automatic cyc(int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // ------
  // Clock and watchdog
  // ------
  initial begin
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (10000) @(posedge clock);
    error_cnt++;
    end_of_test();
  end

  // ------
  // Tests
  // ------
  initial begin
    cyc(3);
    rstn <= 1'h1;
    foreach (rows[i]) begin
      if (rows[i].w) axw(rows[i].ix, rows[i].d, rs);
      axr(rows[i].ix, rd, rs);
      chk("reg", rows[i].e, rd);
    end
    chk("ratio", 12'hA34, ratio);
    chk("fine", FINE_MAX, fineCode);
    axw(IDX_FINE, 8'h09, rs);
    chk("fine", 5'h09, fineCode);
    axr(9'h0D2, rd, rs);
    chk("bad rresp", RESP_SLVERR, rs);
    axw(9'h0D2, 8'h55, rs);
    chk("bad bresp", RESP_SLVERR, rs);
    $display("register tests done");
    foreach (slips[i]) begin
      axw(IDX_CTRL, slips[i].c, rs);
      axw(IDX_SLIP_LOW, slips[i].n[7:0], rs);
      axw(IDX_SLIP_HIGH, {4'h0, slips[i].n[11:8]}, rs);
      @(posedge clock);
      {syncEv, pgEvent, pinSlip} <= 3'h1 << slips[i].w;
      @(posedge clock);
      {syncEv, pgEvent, pinSlip} <= 3'h0;
      if (slips[i].w == 3) axw(IDX_SLIP_CMD, 8'h01, rs);
      busyCnt = 0;
      repeat (300) begin
        @(posedge clock);
        if (slipBusy === 1'h1) busyCnt++;
      end
      chk("slips", slips[i].e, busyCnt);
    end
    axr(IDX_SLIP_CMD, rd, rs);
    chk("slip status", 8'h00, rd);
    $display("slip tests done");
    axw(IDX_SRC, {6'h0, SRC_PARTNER}, rs);
    axw(IDX_IDLE, 8'hA0, rs);
    axw(IDX_CTRL, 8'h0D, rs);
    partnerClk <= 1'h1;
    cyc(4);
    chk("drv idle", 1'h0, drvEn);
    chk("out idle", 1'h0, devOut);
    pgActive <= 1'h1;
    cyc(4);
    chk("drv on", 1'h1, drvEn);
    chk("out partner", 1'h1, devOut);
    partnerClk <= 1'h0;
    cyc(4);
    chk("out low", 1'h0, devOut);
    pgActive <= 1'h0;
    axw(IDX_CTRL, 8'h01, rs);
    cyc(4);
    chk("drv async", 1'h1, drvEn);
    axw(IDX_SRC, 8'h00, rs);
    axw(IDX_DIV_HIGH, 8'h00, rs);
    axw(IDX_DIV_LOW, 8'h01, rs);
    cyc(20);
    rd = {7'h0, devOut};
    cyc(1);
    chk("vco", 1'h1, rd[0] ^ devOut);
    $display("output tests done");
    end_of_test();
  end
endmodule : testbench
